/* hdl/cbx_pkg.sv */
package cbx_pkg;
  typedef enum logic [3:0] {
    ST_FETCH, ST_OPR1, ST_OPR2, ST_EXEC, ST_PUSH_H, ST_PUSH_L,
    ST_POP_L, ST_POP_H, ST_IO_RD, ST_IO_WR, ST_MEM_RD, ST_MEM_WR
  } cbx_st_e;
  typedef enum logic [1:0] {PF_NONE, PF_ED, PF_CB, PF_FD} cbx_pfx_e;
  typedef struct packed {
    cbx_st_e st;
    cbx_pfx_e pfx;
    logic [7:0] op, lo, hi, tmp, wdat, tins;
    logic [15:0] pc, stk, idx2, addr;
    logic [7:0] a, f, b, c, d, e, h, l, ivec, rfsh;
    logic iff1, iff2, nosmp, intk, run, irq1, irq2, ph;
    logic [31:0] tcnt, prdata;
    logic [15:0] icnt;
  } cbx_core_s;
  // Flag positions
  localparam int FL_S = 7;
  localparam int FL_Z = 6;
  localparam int FL_H = 4;
  localparam int FL_PV = 2;
  localparam int FL_N = 1;
  localparam int FL_C = 0;
  // Opcodes
  localparam logic [7:0] OP_PFX_ED = 8'hed;
  localparam logic [7:0] OP_PFX_CB = 8'hcb;
  localparam logic [7:0] OP_PFX_FD = 8'hfd;
  localparam logic [7:0] OP_JP_IDX = 8'he9;
  localparam logic [7:0] OP_DJNZ = 8'h10;
  localparam logic [7:0] OP_JR = 8'h18;
  localparam logic [7:0] OP_CALL = 8'hcd;
  localparam logic [7:0] OP_RET = 8'hc9;
  localparam logic [7:0] OP_IRET = 8'h4d;
  localparam logic [7:0] OP_NRET = 8'h45;
  localparam logic [7:0] OP_DI = 8'hf3;
  localparam logic [7:0] OP_EI = 8'hfb;
  localparam logic [7:0] OP_DECADJ = 8'h27;
  localparam logic [7:0] OP_LDAI = 8'h57;
  localparam logic [7:0] OP_LDAR = 8'h5f;
  localparam logic [7:0] OP_LDI = 8'ha0;
  localparam logic [7:0] OP_CPI = 8'ha1;
  localparam logic [15:0] INT_VEC = 16'h0038;
  // T states per instruction
  localparam logic [7:0] T_BASIC = 8'd4;
  localparam logic [7:0] T_PFX = 8'd8;
  localparam logic [7:0] T_ALU_N = 8'd7;
  localparam logic [7:0] T_LDAI = 8'd9;
  localparam logic [7:0] T_DJNZ_END = 8'd8;
  localparam logic [7:0] T_DJNZ_GO = 8'd13;
  localparam logic [7:0] T_JR_GO = 8'd12;
  localparam logic [7:0] T_JR_SKIP = 8'd7;
  localparam logic [7:0] T_CALL = 8'd17;
  localparam logic [7:0] T_CALL_SKIP = 8'd10;
  localparam logic [7:0] T_RET = 8'd10;
  localparam logic [7:0] T_RET_SKIP = 8'd5;
  localparam logic [7:0] T_IRET = 8'd14;
  localparam logic [7:0] T_RST = 8'd11;
  localparam logic [7:0] T_IN_C = 8'd12;
  localparam logic [7:0] T_BLK = 8'd16;
  localparam logic [7:0] T_BLK_RPT = 8'd21;
  localparam logic [7:0] T_INTACK = 8'd13;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_PC = 8'h08;
  localparam logic [7:0] REG_STACK = 8'h0c;
  localparam logic [7:0] REG_BC = 8'h10;
  localparam logic [7:0] REG_DE = 8'h14;
  localparam logic [7:0] REG_MPTR = 8'h18;
  localparam logic [7:0] REG_IDX2 = 8'h1c;
  localparam logic [7:0] REG_AF = 8'h20;
  localparam logic [7:0] REG_TCNT = 8'h24;
  localparam logic [7:0] REG_ICNT = 8'h28;
endpackage : cbx_pkg

/* hdl/cbx_core.sv */
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module cbx_core (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output logic MEM_REQ,
  output logic MEM_IORQ,
  output logic MEM_WR,
  output logic [15:0] MEM_ADDR,
  output logic [7:0] MEM_WDATA,
  input wire logic [7:0] MEM_RDATA,
  input wire logic MEM_ACK,
  input wire logic INT_REQ,
  output logic IE_STATE,
  output logic BUSY
);
  import cbx_pkg::*;

  cbx_core_s s, n;
  logic fin, eidi, ack, mapped;
  logic [7:0] bm1, rv;

  function automatic logic cond(input logic [2:0] cc, input logic [7:0] f);
    logic v;
    case (cc[2:1])
      2'd0: v = f[FL_Z];
      2'd1: v = f[FL_C];
      2'd2: v = f[FL_PV];
      default: v = f[FL_S];
    endcase
    return cc[0] ? v : ~v;
  endfunction : cond

  function automatic logic [1:0] nopr(input cbx_pfx_e p, input logic [7:0] op);
    if (p != PF_NONE) return 2'd0;
    if (op == OP_DJNZ || op == OP_JR || op == 8'h20 || op == 8'h28 || op == 8'h30
        || op == 8'h38) return 2'd1;
    if (op[7:6] == 2'b11 && op[2:0] == 3'b110) return 2'd1;
    if (op == OP_CALL || (op[7:6] == 2'b11 && op[2:0] == 3'b100)) return 2'd2;
    return 2'd0;
  endfunction : nopr

  function automatic logic [15:0] alu8(input logic [2:0] k, input logic [7:0] a, x, fi);
    logic [8:0] r;
    logic [4:0] hr;
    logic [7:0] f;
    f = fi;
    r = {1'b0, a};
    hr = 5'd0;
    case (k)
      3'b000: begin
        r = {1'b0, a} + {1'b0, x};
        hr = {1'b0, a[3:0]} + {1'b0, x[3:0]};
        f[FL_H] = hr[4];
        f[FL_PV] = (a[7] == x[7]) && (r[7] != a[7]);
        f[FL_N] = 1'b0;
        f[FL_C] = r[8];
      end
      3'b010: begin
        r = {1'b0, a} - {1'b0, x};
        hr = {1'b0, a[3:0]} - {1'b0, x[3:0]};
        f[FL_H] = hr[4];
        f[FL_PV] = (a[7] != x[7]) && (r[7] != a[7]);
        f[FL_N] = 1'b1;
        f[FL_C] = r[8];
      end
      3'b100, 3'b101, 3'b110: begin
        r = {1'b0, (k == 3'b100) ? (a & x) : (k == 3'b101) ? (a ^ x) : (a | x)};
        f[FL_H] = (k == 3'b100);
        f[FL_PV] = ~^r[7:0];
        f[FL_N] = 1'b0;
        f[FL_C] = 1'b0;
      end
      default: ;
    endcase
    f[FL_S] = r[7];
    f[FL_Z] = (r[7:0] == 8'h00);
    return {f, r[7:0]};
  endfunction : alu8

  function automatic logic [15:0] dec_adj(input logic [7:0] a, fi);
    logic [7:0] cor, r, f;
    f = fi;
    cor = 8'h00;
    if (f[FL_H] || a[3:0] > 4'd9) cor[3:0] = 4'h6;
    if (f[FL_C] || a > 8'h99) begin
      cor[7:4] = 4'h6;
      f[FL_C] = 1'b1;
    end
    r = f[FL_N] ? a - cor : a + cor;
    f[FL_H] = f[FL_N] ? (f[FL_H] && a[3:0] < 4'd6) : (a[3:0] > 4'd9);
    f[FL_S] = r[7];
    f[FL_Z] = (r == 8'h00);
    f[FL_PV] = ~^r;
    return {f, r};
  endfunction : dec_adj

  assign ack = MEM_REQ && MEM_ACK;
  assign MEM_REQ = (s.st != ST_EXEC) && !(s.st == ST_FETCH && !s.run);
  assign MEM_IORQ = (s.st == ST_IO_RD) || (s.st == ST_IO_WR);
  assign MEM_WR = (s.st inside {ST_PUSH_H, ST_PUSH_L, ST_IO_WR, ST_MEM_WR});
  assign MEM_ADDR = s.addr;
  assign MEM_WDATA = s.wdat;
  assign PRDATA = s.prdata;
  assign PREADY = s.ph;
  assign mapped = (PADDR[1:0] == 2'b00) && (PADDR <= REG_ICNT);
  assign PSLVERR = s.ph && PENABLE && !mapped;
  assign IE_STATE = s.iff1;
  assign BUSY = s.run || (s.st != ST_FETCH);

  always_comb begin
    n = s;
    fin = 1'b0;
    eidi = 1'b0;
    bm1 = s.b - 8'h01;
    rv = 8'h00;
    n.irq1 = INT_REQ;
    n.irq2 = s.irq1;
    // ==================== Instruction sequencing
    case (s.st)
      ST_FETCH: if (ack) begin
        n.pc = s.pc + 16'h0001;
        n.rfsh = {s.rfsh[7], s.rfsh[6:0] + 7'h01};
        n.op = MEM_RDATA;
        if (s.pfx == PF_NONE && MEM_RDATA == OP_PFX_ED) n.pfx = PF_ED;
        else if (s.pfx == PF_NONE && MEM_RDATA == OP_PFX_CB) n.pfx = PF_CB;
        else if (s.pfx == PF_NONE && MEM_RDATA == OP_PFX_FD) n.pfx = PF_FD;
        else n.st = (nopr(s.pfx, MEM_RDATA) != 2'd0) ? ST_OPR1 : ST_EXEC;
      end
      ST_OPR1: if (ack) begin
        n.lo = MEM_RDATA;
        n.pc = s.pc + 16'h0001;
        n.st = (nopr(s.pfx, s.op) == 2'd2) ? ST_OPR2 : ST_EXEC;
      end
      ST_OPR2: if (ack) begin
        n.hi = MEM_RDATA;
        n.pc = s.pc + 16'h0001;
        n.st = ST_EXEC;
      end
      ST_EXEC: begin
        fin = 1'b1;
        n.tins = (s.pfx == PF_NONE) ? T_BASIC : T_PFX;
        case (s.pfx)
          PF_NONE: begin
            if (s.op == OP_DI || s.op == OP_EI) begin
              n.iff1 = (s.op == OP_EI);
              n.iff2 = (s.op == OP_EI);
              eidi = 1'b1;
            end else if (s.op == OP_DECADJ) begin
              {n.f, n.a} = dec_adj(s.a, s.f);
            end else if (s.op == OP_DJNZ) begin
              n.b = bm1;
              n.tins = (bm1 == 8'h00) ? T_DJNZ_END : T_DJNZ_GO;
              if (bm1 != 8'h00) n.pc = s.pc + {{8{s.lo[7]}}, s.lo};
            end else if (s.op == OP_JR || s.op == 8'h20 || s.op == 8'h28 || s.op == 8'h30
                         || s.op == 8'h38) begin
              if (s.op == OP_JR || cond({1'b0, s.op[4:3]}, s.f)) begin
                n.pc = s.pc + {{8{s.lo[7]}}, s.lo};
                n.tins = T_JR_GO;
              end else n.tins = T_JR_SKIP;
            end else if (s.op == OP_CALL || (s.op[7:6] == 2'b11 && s.op[2:0] == 3'b100)) begin
              if (s.op == OP_CALL || cond(s.op[5:3], s.f)) begin
                fin = 1'b0;
                n.st = ST_PUSH_H;
                n.tins = T_CALL;
              end else n.tins = T_CALL_SKIP;
            end else if (s.op == OP_RET || (s.op[7:6] == 2'b11 && s.op[2:0] == 3'b000)) begin
              if (s.op == OP_RET || cond(s.op[5:3], s.f)) begin
                fin = 1'b0;
                n.st = ST_POP_L;
                n.tins = T_RET;
              end else n.tins = T_RET_SKIP;
            end else if (s.op[7:6] == 2'b11 && s.op[2:0] == 3'b111) begin
              fin = 1'b0;
              n.hi = 8'h00;
              n.lo = {2'b00, s.op[5:3], 3'b000};
              n.st = ST_PUSH_H;
              n.tins = T_RST;
            end else if (s.op[7:6] == 2'b11 && s.op[2:0] == 3'b110) begin
              {n.f, n.a} = alu8(s.op[5:3], s.a, s.lo, s.f);
              n.tins = T_ALU_N;
            end
          end
          PF_ED: begin
            if (s.op == OP_IRET || s.op == OP_NRET) begin
              fin = 1'b0;
              if (s.op == OP_NRET) n.iff1 = s.iff2;
              n.st = ST_POP_L;
              n.tins = T_IRET;
            end else if (s.op == OP_LDAI || s.op == OP_LDAR) begin
              rv = (s.op == OP_LDAI) ? s.ivec : s.rfsh;
              n.a = rv;
              n.f[FL_S] = rv[7];
              n.f[FL_Z] = (rv == 8'h00);
              n.f[FL_PV] = s.iff2;
              n.f[FL_H] = 1'b0;
              n.f[FL_N] = 1'b0;
              n.tins = T_LDAI;
            end else if (s.op[7:6] == 2'b01 && s.op[2:0] == 3'b000) begin
              fin = 1'b0;
              n.st = ST_IO_RD;
              n.tins = T_IN_C;
            end else if (s.op[7:5] == 3'b101 && s.op[2:1] == 2'b01) begin
              fin = 1'b0;
              n.st = s.op[0] ? ST_MEM_RD : ST_IO_RD;
              n.tins = T_BLK;
            end else if (s.op == OP_LDI || s.op == OP_CPI) begin
              fin = 1'b0;
              n.st = ST_MEM_RD;
              n.tins = T_BLK;
            end
          end
          PF_CB: if (s.op[7:6] == 2'b01 && s.op[2:0] != 3'b110) begin
            case (s.op[2:0])
              3'd0: rv = s.b;
              3'd1: rv = s.c;
              3'd2: rv = s.d;
              3'd3: rv = s.e;
              3'd4: rv = s.h;
              3'd5: rv = s.l;
              default: rv = s.a;
            endcase
            n.f[FL_Z] = ~rv[s.op[5:3]];
            n.f[FL_H] = 1'b1;
            n.f[FL_N] = 1'b0;
          end
          default: if (s.op == OP_JP_IDX) n.pc = s.idx2;
        endcase
      end
      ST_PUSH_H: if (ack) begin
        n.stk = s.stk - 16'h0001;
        n.st = ST_PUSH_L;
      end
      ST_PUSH_L: if (ack) begin
        n.stk = s.stk - 16'h0001;
        n.pc = {s.hi, s.lo};
        fin = 1'b1;
      end
      ST_POP_L: if (ack) begin
        n.lo = MEM_RDATA;
        n.stk = s.stk + 16'h0001;
        n.st = ST_POP_H;
      end
      ST_POP_H: if (ack) begin
        n.pc = {MEM_RDATA, s.lo};
        n.stk = s.stk + 16'h0001;
        fin = 1'b1;
      end
      ST_IO_RD: if (ack) begin
        n.tmp = MEM_RDATA;
        if (s.op[7:6] == 2'b01) begin
          case (s.op[5:3])
            3'd0: n.b = MEM_RDATA;
            3'd1: n.c = MEM_RDATA;
            3'd2: n.d = MEM_RDATA;
            3'd3: n.e = MEM_RDATA;
            3'd4: n.h = MEM_RDATA;
            3'd5: n.l = MEM_RDATA;
            3'd7: n.a = MEM_RDATA;
            default: ;
          endcase
          n.f[FL_S] = MEM_RDATA[7];
          n.f[FL_Z] = (MEM_RDATA == 8'h00);
          n.f[FL_PV] = ~^MEM_RDATA;
          n.f[FL_H] = 1'b0;
          n.f[FL_N] = 1'b0;
          fin = 1'b1;
        end else n.st = ST_MEM_WR;
      end
      ST_MEM_RD: if (ack) begin
        n.tmp = MEM_RDATA;
        if (s.op == OP_CPI) begin
          {n.h, n.l} = {s.h, s.l} + 16'h0001;
          {n.b, n.c} = {s.b, s.c} - 16'h0001;
          n.f[FL_Z] = (s.a == MEM_RDATA);
          n.f[FL_N] = 1'b1;
          n.f[FL_PV] = ({s.b, s.c} != 16'h0001);
          fin = 1'b1;
        end else n.st = (s.op == OP_LDI) ? ST_MEM_WR : ST_IO_WR;
      end
      ST_MEM_WR, ST_IO_WR: if (ack) begin
        fin = 1'b1;
        if (s.op == OP_LDI) begin
          {n.h, n.l} = {s.h, s.l} + 16'h0001;
          {n.d, n.e} = {s.d, s.e} + 16'h0001;
          {n.b, n.c} = {s.b, s.c} - 16'h0001;
          n.f[FL_PV] = ({s.b, s.c} != 16'h0001);
          n.f[FL_H] = 1'b0;
          n.f[FL_N] = 1'b0;
        end else begin
          n.b = bm1;
          {n.h, n.l} = s.op[3] ? {s.h, s.l} - 16'h0001 : {s.h, s.l} + 16'h0001;
          n.f[FL_Z] = (bm1 == 8'h00);
          n.f[FL_N] = 1'b1;
          if (s.op[4] && bm1 != 8'h00) begin
            n.pc = s.pc - 16'h0002;
            n.tins = T_BLK_RPT;
          end
        end
      end
      default: n.st = ST_FETCH;
    endcase
    // ==================== Completion and interrupt sampling
    if (fin) begin
      n.tcnt = s.tcnt + {24'h000000, n.tins};
      n.icnt = s.icnt + 16'h0001;
      n.pfx = PF_NONE;
      n.st = ST_FETCH;
      n.intk = 1'b0;
      n.nosmp = eidi;
      if (s.irq2 && n.iff1 && !eidi) begin
        n.intk = 1'b1;
        n.iff1 = 1'b0;
        n.iff2 = 1'b0;
        {n.hi, n.lo} = INT_VEC;
        n.tins = T_INTACK;
        n.st = ST_PUSH_H;
      end
    end
    // ==================== Bus address and write data
    case (n.st)
      ST_FETCH, ST_OPR1, ST_OPR2: n.addr = n.pc;
      ST_PUSH_H: begin
        n.addr = n.stk - 16'h0001;
        n.wdat = n.pc[15:8];
      end
      ST_PUSH_L: begin
        n.addr = n.stk - 16'h0001;
        n.wdat = n.pc[7:0];
      end
      ST_POP_L, ST_POP_H: n.addr = n.stk;
      ST_IO_RD, ST_IO_WR: begin
        n.addr = {n.b, n.c};
        n.wdat = n.tmp;
      end
      ST_MEM_RD: n.addr = {n.h, n.l};
      ST_MEM_WR: begin
        n.addr = (n.op == OP_LDI && n.pfx == PF_ED) ? {n.d, n.e} : {n.h, n.l};
        n.wdat = n.tmp;
      end
      default: ;
    endcase
    // ==================== APB slave, zero wait after setup capture
    if (PSEL && !s.ph) begin
      n.ph = 1'b1;
      case (PADDR)
        REG_CTRL: n.prdata = {31'h0, s.run};
        REG_STATUS: n.prdata = {22'h0, s.st, s.pfx, s.intk, s.nosmp, s.iff2, s.iff1};
        REG_PC: n.prdata = {16'h0, s.pc};
        REG_STACK: n.prdata = {16'h0, s.stk};
        REG_BC: n.prdata = {16'h0, s.b, s.c};
        REG_DE: n.prdata = {16'h0, s.d, s.e};
        REG_MPTR: n.prdata = {16'h0, s.h, s.l};
        REG_IDX2: n.prdata = {16'h0, s.idx2};
        REG_AF: n.prdata = {16'h0, s.a, s.f};
        REG_TCNT: n.prdata = s.tcnt;
        REG_ICNT: n.prdata = {16'h0, s.icnt};
        default: n.prdata = 32'h0;
      endcase
    end
    if (PSEL && PENABLE && s.ph) begin
      n.ph = 1'b0;
      if (PWRITE) begin
        case (PADDR)
          REG_CTRL: n.run = PWDATA[0];
          REG_PC: n.pc = PWDATA[15:0];
          REG_STACK: n.stk = PWDATA[15:0];
          REG_BC: {n.b, n.c} = PWDATA[15:0];
          REG_DE: {n.d, n.e} = PWDATA[15:0];
          REG_MPTR: {n.h, n.l} = PWDATA[15:0];
          REG_IDX2: n.idx2 = PWDATA[15:0];
          REG_AF: {n.a, n.f} = PWDATA[15:0];
          REG_TCNT: n.tcnt = PWDATA;
          REG_ICNT: n.icnt = PWDATA[15:0];
          default: ;
        endcase
        if (PADDR == REG_PC && n.st == ST_FETCH) n.addr = PWDATA[15:0];
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (RST) s <= '0;
    else if (CE) s <= n;
  end

  // ==================== Checks
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);

  property p_jp_idx;
    fin && CE && s.st == ST_EXEC && s.pfx == PF_FD && s.op == OP_JP_IDX && !n.intk
      |=> s.pc == $past(s.idx2) && s.tcnt == $past(s.tcnt) + 32'd8;
  endproperty
  a_jp_idx: assert property (p_jp_idx) else $error("indexed jump wrong");

  property p_djnz;
    CE && s.st == ST_EXEC && s.pfx == PF_NONE && s.op == OP_DJNZ
      |=> s.b == $past(s.b) - 8'h01
        && (s.b == 8'h00 || s.pc == $past(s.pc) + {{8{$past(s.lo[7])}}, $past(s.lo)});
  endproperty
  a_djnz: assert property (p_djnz) else $error("loop branch wrong");

  property p_jr;
    CE && s.st == ST_EXEC && s.pfx == PF_NONE && s.op == OP_JR
      |=> s.pc == $past(s.pc) + {{8{$past(s.lo[7])}}, $past(s.lo)};
  endproperty
  a_jr: assert property (p_jr) else $error("relative target wrong");

  property p_push_hi;
    MEM_REQ && s.st == ST_PUSH_H |-> MEM_WR && MEM_ADDR == s.stk - 16'h0001
      && MEM_WDATA == s.pc[15:8];
  endproperty
  a_push_hi: assert property (p_push_hi) else $error("push high wrong");

  property p_call_skip;
    CE && s.st == ST_EXEC && s.pfx == PF_NONE && s.op[7:6] == 2'b11 && s.op[2:0] == 3'b100
      && !cond(s.op[5:3], s.f) |=> s.stk == $past(s.stk) && s.tcnt == $past(s.tcnt) + 32'd10;
  endproperty
  a_call_skip: assert property (p_call_skip) else $error("false call wrong");

  property p_ret_skip;
    CE && s.st == ST_EXEC && s.pfx == PF_NONE && s.op[7:6] == 2'b11 && s.op[2:0] == 3'b000
      && !cond(s.op[5:3], s.f) |=> s.stk == $past(s.stk) && s.tcnt == $past(s.tcnt) + 32'd5;
  endproperty
  a_ret_skip: assert property (p_ret_skip) else $error("false return wrong");

  property p_io_addr;
    MEM_REQ && MEM_IORQ |-> MEM_ADDR == {s.b, s.c};
  endproperty
  a_io_addr: assert property (p_io_addr) else $error("port address wrong");

  property p_blk_rpt;
    CE && ack && s.st == ST_IO_WR && s.op[4] && s.b != 8'h01
      |=> s.pc == $past(s.pc) - 16'h0002 && s.tcnt == $past(s.tcnt) + 32'd21;
  endproperty
  a_blk_rpt: assert property (p_blk_rpt) else $error("repeat timing wrong");

  property p_blk_flags;
    CE && ack && (s.st == ST_IO_WR || (s.st == ST_MEM_WR && s.op != OP_LDI))
      |=> s.f[FL_N] && (s.f[FL_Z] == (s.b == 8'h00));
  endproperty
  a_blk_flags: assert property (p_blk_flags) else $error("block flags wrong");

  property p_ei_nosample;
    fin && CE && eidi |=> !s.intk;
  endproperty
  a_ei_nosample: assert property (p_ei_nosample) else $error("sampled after enable");

  c_call: cover property (s.st == ST_PUSH_L && ack && s.op == OP_CALL);
  c_rpt: cover property (s.st == ST_IO_WR && ack && s.op[4] && s.b != 8'h01);
  c_int: cover property (s.intk && s.st == ST_PUSH_L && ack);
endmodule : cbx_core

/* testbench/cbx_mem_model.sv */
`timescale 1ns/1ps
module cbx_mem_model (
  input wire logic clk,
  input wire logic slow,
  input wire logic req,
  input wire logic iorq,
  input wire logic wr,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata,
  output logic ack
);
  logic [7:0] mem [0:255];
  logic [7:0] last;
  logic [15:0] io_addr;
  logic tog;
  // Port data derived from the port address
  function automatic logic [7:0] port_val(input logic [15:0] a);
    return a[7:0] ^ 8'h5a;
  endfunction : port_val
  // Slow mode acknowledges every other cycle
  assign ack = req & (~slow | tog);
  // Released bus shows the inverse of the last byte
  assign rdata = req ? (iorq ? port_val(addr) : mem[addr[7:0]]) : ~last;
  initial begin
    tog = 1'b0;
    last = 8'h00;
    io_addr = 16'h0000;
  end
  always @(posedge clk) begin
    tog <= ~tog;
    if (req && ack) begin
      last <= rdata;
      if (iorq) begin
        io_addr <= addr;
      end
      if (wr && !iorq) begin
        mem[addr[7:0]] <= wdata;
      end
    end
  end
endmodule : cbx_mem_model

/* testbench/cbx_core_bench.sv */
`timescale 1ns/1ps
module cbx_core_bench;
  import cbx_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, mreq, miorq, mwr, mack, busy, err, ie;
  logic int_req = 1'b0;
  logic [15:0] maddr;
  logic [7:0] mwdata, mrdata;
  int mismatches = 0, n_compared = 0;
  always #50 clk = ~clk;
  cbx_core i_dut (.REF_CLK(clk), .RST(rst), .CE(1'b1), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .MEM_REQ(mreq), .MEM_IORQ(miorq), .MEM_WR(mwr), .MEM_ADDR(maddr),
    .MEM_WDATA(mwdata), .MEM_RDATA(mrdata), .MEM_ACK(mack), .INT_REQ(int_req),
    .IE_STATE(ie), .BUSY(busy));
  cbx_mem_model i_mem (.clk(clk), .slow(1'b1), .req(mreq), .iorq(miorq), .wr(mwr),
    .addr(maddr), .wdata(mwdata), .rdata(mrdata), .ack(mack));
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic tally_and_finish;
    if (mismatches == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : tally_and_finish
  // ==========================================
  // Register access and refusal
  task automatic t_regs;
    apb(1'b0, REG_STACK, 32'h0);
    chk("stack_reset", rd, 32'h0);
    chk("ie_reset", {31'h0, ie}, 32'h0);
    apb(1'b0, 8'h2c, 32'h0);
    chk("unmapped_err", {31'h0, err}, 32'h1);
    chk("unmapped_data", rd, 32'h0);
  endtask : t_regs
  // ==========================================
  // Call, returns, loop, indexed jump, block input
  task automatic t_program;
    logic [31:0] icnt;
    apb(1'b1, REG_STACK, 32'h80);
    apb(1'b1, REG_IDX2, 32'h20);
    apb(1'b1, REG_BC, 32'h0205);
    apb(1'b1, REG_MPTR, 32'h40);
    apb(1'b1, REG_AF, 32'h0);
    apb(1'b1, REG_CTRL, 32'h1);
    while (i_mem.mem[8'h40] !== 8'h5f) @(posedge clk);
    apb(1'b1, REG_CTRL, 32'h0);
    while (busy !== 1'b0) @(posedge clk);
    apb(1'b0, REG_PC, 32'h0);
    chk("pc", rd, 32'h22);
    apb(1'b0, REG_STACK, 32'h0);
    chk("stack", rd, 32'h80);
    chk("push_hi", {24'h0, i_mem.mem[8'h7f]}, 32'h0);
    chk("push_lo", {24'h0, i_mem.mem[8'h7e]}, 32'h3);
    chk("io_addr", {16'h0, i_mem.io_addr}, 32'h0005);
    apb(1'b0, REG_BC, 32'h0);
    chk("bc", rd, 32'hff05);
    apb(1'b0, REG_MPTR, 32'h0);
    chk("mptr", rd, 32'h41);
    apb(1'b0, REG_AF, 32'h0);
    chk("af", rd, 32'h0002);
    apb(1'b0, REG_ICNT, 32'h0);
    icnt = rd;
    apb(1'b0, REG_TCNT, 32'h0);
    chk("tstates", rd, 32'd77 + 32'd12 * (icnt - 32'd7));
  endtask : t_program
  // ==========================================
  // Enable, one more instruction, then interrupt accept
  task automatic t_intr;
    int_req <= 1'b1;
    apb(1'b1, REG_STACK, 32'h80);
    apb(1'b1, REG_PC, 32'h50);
    apb(1'b1, REG_CTRL, 32'h1);
    while (i_mem.mem[8'h7e] !== 8'h52) @(posedge clk);
    int_req <= 1'b0;
    apb(1'b1, REG_CTRL, 32'h0);
    while (busy !== 1'b0) @(posedge clk);
    chk("int_ret_lo", {24'h0, i_mem.mem[8'h7e]}, 32'h52);
    chk("int_ret_hi", {24'h0, i_mem.mem[8'h7f]}, 32'h0);
    chk("ie_cleared", {31'h0, ie}, 32'h0);
    apb(1'b0, REG_PC, 32'h0);
    chk("int_pc", rd, 32'h38);
  endtask : t_intr
  initial begin
    // CALL 10; RET Z skipped; loop on B; jump via index; block in; self loop
    i_mem.mem[8'h00] = 8'hcd;
    i_mem.mem[8'h01] = 8'h10;
    i_mem.mem[8'h02] = 8'h00;
    i_mem.mem[8'h03] = 8'hc8;
    i_mem.mem[8'h04] = 8'h10;
    i_mem.mem[8'h05] = 8'hfe;
    i_mem.mem[8'h06] = 8'hfd;
    i_mem.mem[8'h07] = 8'he9;
    i_mem.mem[8'h10] = 8'hc9;
    i_mem.mem[8'h20] = 8'hed;
    i_mem.mem[8'h21] = 8'ha2;
    i_mem.mem[8'h22] = 8'h18;
    i_mem.mem[8'h23] = 8'hfe;
    i_mem.mem[8'h40] = 8'h00;
    i_mem.mem[8'h38] = 8'h18;
    i_mem.mem[8'h39] = 8'hfe;
    i_mem.mem[8'h50] = 8'hfb;
    i_mem.mem[8'h51] = 8'h00;
    i_mem.mem[8'h52] = 8'h18;
    i_mem.mem[8'h53] = 8'hfe;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_program();
    t_intr();
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    tally_and_finish();
  end
endmodule : cbx_core_bench
